// File: rtl/pwd_pkg.sv
// constants, types and helpers of the planar write/read datapath
package pwd_pkg;
    // ===========================================
    // indexed register map behind the data port
    localparam logic [3:0] PWD_IDX_SET_RESET = 4'h0;
    localparam logic [3:0] PWD_IDX_SR_ENABLE = 4'h1;
    localparam logic [3:0] PWD_IDX_CMP_COLOR = 4'h2;
    localparam logic [3:0] PWD_IDX_ROTATE = 4'h3;
    localparam logic [3:0] PWD_IDX_PLANE_SEL = 4'h4;
    localparam logic [3:0] PWD_IDX_MODE = 4'h5;
    localparam logic [3:0] PWD_IDX_MISC = 4'h6;
    localparam logic [3:0] PWD_IDX_CARE = 4'h7;
    localparam logic [3:0] PWD_IDX_MASK = 4'h8;
    // ===========================================
    // field positions
    localparam int PWD_ROT_LSB = 0;
    localparam int PWD_FUNC_LSB = 3;
    localparam int PWD_WMODE_LSB = 0;
    localparam int PWD_RMODE_BIT = 3;
    localparam int PWD_ODDEVEN_BIT = 4;
    localparam int PWD_ALT_LOAD_BIT = 5;
    localparam int PWD_COLOR256_BIT = 6;
    localparam int PWD_GFX_BIT = 0;
    localparam int PWD_CHAIN_BIT = 1;
    localparam int PWD_MAP_LSB = 2;
    // ===========================================
    // reset values and the all-planes write enable
    localparam logic [7:0] PWD_RST_BYTE = 8'h00;
    localparam logic [3:0] PWD_RST_NIB = 4'h0;
    localparam logic [7:0] PWD_RST_MASK = 8'hFF;
    localparam logic [3:0] PWD_PLANES_ALL = 4'hF;
    // ===========================================
    // modes
    typedef enum logic [1:0] {
        PWD_WM0 = 2'b00,
        PWD_WM1 = 2'b01,
        PWD_WM2 = 2'b10,
        PWD_WM3 = 2'b11
    } pwd_wmode_t;
    typedef enum logic [1:0] {
        PWD_FN_MOVE = 2'b00,
        PWD_FN_AND = 2'b01,
        PWD_FN_OR = 2'b10,
        PWD_FN_XOR = 2'b11
    } pwd_func_t;
    // circular right rotate, bit 0 wraps into bit 7
    function automatic logic [7:0] pwd_rotr(input logic [7:0] d,
                                           input logic [2:0] n);
        logic [15:0] w;
        w = {d, d} >> n;
        return w[7:0];
    endfunction
endpackage

// File: rtl/pwd_alu_if.sv
// carrier between register/read logic and the per-plane write unit
`timescale 1ns/1ps
interface pwd_alu_if;
    import pwd_pkg::*;
    logic [7:0] host_data;
    logic [31:0] latch;
    pwd_wmode_t write_mode;
    pwd_func_t func;
    logic [2:0] rot_cnt;
    logic [7:0] bit_mask;
    logic [3:0] sr_value;
    logic [3:0] sr_enable;
    logic [31:0] plane_data;
    modport ctrl (output host_data, latch, write_mode, func, rot_cnt,
                  bit_mask, sr_value, sr_enable, input plane_data);
    modport alu (input host_data, latch, write_mode, func, rot_cnt,
                 bit_mask, sr_value, sr_enable, output plane_data);
endinterface

// File: rtl/pwd_plane_alu.sv
// per-plane write data path: source select, logic function, bit mask
`timescale 1ns/1ps
module pwd_plane_alu
    import pwd_pkg::*;
(
    pwd_alu_if.alu bus
);
    // ===========================================
    // shared terms
    wire [7:0] rotated;
    wire [7:0] eff_mask;
    assign rotated = pwd_rotr(bus.host_data, bus.rot_cnt);
    // mode 3 narrows the mask with the rotated host byte
    assign eff_mask = (bus.write_mode == PWD_WM3) ?
        (rotated & bus.bit_mask) : bus.bit_mask;

    // ===========================================
    // one lane per plane
    for (genvar p = 0; p < 4; p++) begin : g_plane
        wire [7:0] lat;
        wire [7:0] sr_byte;
        wire [7:0] src;
        wire [7:0] res;
        assign lat = bus.latch[p*8 +: 8];
        assign sr_byte = {8{bus.sr_value[p]}};
        // mode 3 always uses set/reset; 0 and 2 only where enabled
        assign src =
            (bus.write_mode == PWD_WM3) ? sr_byte :
            bus.sr_enable[p] ? sr_byte :
            (bus.write_mode == PWD_WM2) ?
                {8{bus.host_data[p]}} :
            rotated;
        assign res =
            (bus.func == PWD_FN_AND) ? (src & lat) :
            (bus.func == PWD_FN_OR) ? (src | lat) :
            (bus.func == PWD_FN_XOR) ? (src ^ lat) :
            src;
        // mode 1 writes the latch whole, function and mask ignored
        assign bus.plane_data[p*8 +: 8] =
            (bus.write_mode == PWD_WM1) ? lat :
            ((res & eff_mask) | (lat & ~eff_mask));
    end
endmodule // pwd_plane_alu

// File: rtl/pwd_datapath.sv
// planar graphics data controller write/read datapath, top level
`timescale 1ns/1ps
module pwd_datapath
    import pwd_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    // register ports: index port and shared data port
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic IO_DATA_SEL,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    // registers kept outside this block
    input wire logic [3:0] SR_VALUE,
    input wire logic [3:0] SR_ENABLE,
    input wire logic [3:0] CMP_COLOR,
    // host display memory access
    input wire logic MEM_WR,
    input wire logic MEM_RD,
    input wire logic HOST_A0,
    input wire logic HOST_A_HIGH,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    output logic HOST_RVALID,
    // display memory planes
    input wire logic [31:0] PLANE_RDATA,
    output logic [31:0] PLANE_WDATA,
    output logic [3:0] PLANE_WE,
    output logic PLANE_A0,
    // mode outputs to neighbouring units
    output logic [1:0] MEMORY_MAP,
    output logic GRAPHICS_MODE,
    output logic CHAIN_EN,
    output logic ATTR_LOAD_256,
    output logic ATTR_LOAD_ALT
);
    // ===========================================
    // register state
    logic [3:0] index;
    logic [4:0] rotate_and_logic_select;
    logic [1:0] read_plane_choice;
    logic [7:0] read_write_mode_control;
    logic [3:0] memory_map_and_graphics_control;
    logic [3:0] compare_plane_participation;
    logic [7:0] write_bit_mask;
    logic [31:0] latch;

    // ===========================================
    // register port decode
    wire idx_wr;
    wire data_wr;
    assign idx_wr = IO_WR && !IO_DATA_SEL;
    assign data_wr = IO_WR && IO_DATA_SEL;

    wire wr_rotate;
    wire wr_plane;
    wire wr_mode;
    wire wr_misc;
    wire wr_care;
    wire wr_mask;
    assign wr_rotate = data_wr && (index == PWD_IDX_ROTATE);
    assign wr_plane = data_wr && (index == PWD_IDX_PLANE_SEL);
    assign wr_mode = data_wr && (index == PWD_IDX_MODE);
    assign wr_misc = data_wr && (index == PWD_IDX_MISC);
    assign wr_care = data_wr && (index == PWD_IDX_CARE);
    assign wr_mask = data_wr && (index == PWD_IDX_MASK);

    // writable bits only; reserved positions and the PWD_ALT_LOAD_BIT position stay zero
    wire [7:0] mode_wmask;
    assign mode_wmask = 8'h5B;

    // ===========================================
    // field views
    wire [1:0] func_sel;
    wire [2:0] rot_cnt;
    wire [1:0] wmode;
    wire read_cmp;
    wire odd_even_rd;
    assign func_sel = rotate_and_logic_select[PWD_FUNC_LSB +: 2];
    assign rot_cnt = rotate_and_logic_select[PWD_ROT_LSB +: 3];
    assign wmode = read_write_mode_control[PWD_WMODE_LSB +: 2];
    assign read_cmp = read_write_mode_control[PWD_RMODE_BIT];
    assign odd_even_rd = read_write_mode_control[PWD_ODDEVEN_BIT];

    // ===========================================
    // register read-back, unmapped indices read zero
    logic [7:0] data_port_q;
    always_comb begin
        unique case (index)
            PWD_IDX_SET_RESET: data_port_q = {4'h0, SR_VALUE};
            PWD_IDX_SR_ENABLE: data_port_q = {4'h0, SR_ENABLE};
            PWD_IDX_CMP_COLOR: data_port_q = {4'h0, CMP_COLOR};
            PWD_IDX_ROTATE: data_port_q = {3'h0, rotate_and_logic_select};
            PWD_IDX_PLANE_SEL: data_port_q = {6'h00, read_plane_choice};
            PWD_IDX_MODE: data_port_q = read_write_mode_control;
            PWD_IDX_MISC: data_port_q = {4'h0,
                memory_map_and_graphics_control};
            PWD_IDX_CARE: data_port_q = {4'h0, compare_plane_participation};
            PWD_IDX_MASK: data_port_q = write_bit_mask;
            default: data_port_q = PWD_RST_BYTE;
        endcase
    end

    wire [7:0] next_io_rdata;
    assign next_io_rdata = IO_DATA_SEL ? data_port_q : {4'h0, index};

    // ===========================================
    // index and indexed registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            index <= PWD_RST_NIB;
        end else if (idx_wr) begin
            index <= IO_WDATA[3:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rotate_and_logic_select <= PWD_RST_BYTE[4:0];
            read_plane_choice <= PWD_RST_BYTE[1:0];
            read_write_mode_control <= PWD_RST_BYTE;
        end else begin
            if (wr_rotate) begin
                rotate_and_logic_select <= IO_WDATA[4:0];
            end
            if (wr_plane) begin
                read_plane_choice <= IO_WDATA[1:0];
            end
            if (wr_mode) begin
                read_write_mode_control <= IO_WDATA & mode_wmask;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            memory_map_and_graphics_control <= PWD_RST_NIB;
            compare_plane_participation <= PWD_RST_NIB;
            write_bit_mask <= PWD_RST_MASK;
        end else begin
            if (wr_misc) begin
                memory_map_and_graphics_control <= IO_WDATA[3:0];
            end
            if (wr_care) begin
                compare_plane_participation <= IO_WDATA[3:0];
            end
            if (wr_mask) begin
                write_bit_mask <= IO_WDATA;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            IO_RDATA <= PWD_RST_BYTE;
        end else if (IO_RD) begin
            IO_RDATA <= next_io_rdata;
        end
    end

    // ===========================================
    // mode outputs
    wire chain;
    assign chain = memory_map_and_graphics_control[PWD_CHAIN_BIT];
    // the map field is only steered here; software keeps it zero
    // in linear configurations
    assign MEMORY_MAP =
        memory_map_and_graphics_control[PWD_MAP_LSB +: 2];
    assign GRAPHICS_MODE =
        memory_map_and_graphics_control[PWD_GFX_BIT];
    assign CHAIN_EN = chain;
    assign ATTR_LOAD_256 =
        read_write_mode_control[PWD_COLOR256_BIT];
    assign ATTR_LOAD_ALT = !read_write_mode_control[PWD_COLOR256_BIT] &&
        read_write_mode_control[PWD_ALT_LOAD_BIT];

    // ===========================================
    // address bit 0 toward memory and chained plane enables
    wire next_plane_a0;
    wire [3:0] next_plane_we;
    assign next_plane_a0 = chain ? HOST_A_HIGH : HOST_A0;
    // chained: even address hits even planes, odd address odd planes
    assign next_plane_we = !chain ? PWD_PLANES_ALL :
        (HOST_A0 ? 4'b1010 : 4'b0101);

    // ===========================================
    // read path
    wire [1:0] rd_plane;
    wire [7:0] plane_byte;
    wire [7:0] cmp_byte;
    // odd/even keeps the pair, address bit 0 picks the member
    assign rd_plane = odd_even_rd ?
        {read_plane_choice[1], HOST_A0} : read_plane_choice;
    assign plane_byte = PLANE_RDATA[rd_plane*8 +: 8];

    for (genvar i = 0; i < 8; i++) begin : g_pixel
        wire [3:0] colour;
        assign colour = {PLANE_RDATA[24 + i], PLANE_RDATA[16 + i],
                         PLANE_RDATA[8 + i], PLANE_RDATA[i]};
        // a plane with its care bit clear cannot cause a mismatch
        assign cmp_byte[i] = ~|((colour ^ CMP_COLOR) &
            compare_plane_participation);
    end

    wire [7:0] next_host_rdata;
    assign next_host_rdata = read_cmp ? cmp_byte : plane_byte;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            HOST_RDATA <= PWD_RST_BYTE;
            HOST_RVALID <= 1'b0;
        end else begin
            HOST_RVALID <= MEM_RD;
            if (MEM_RD) begin
                HOST_RDATA <= next_host_rdata;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            latch <= {4{PWD_RST_BYTE}};
        end else if (MEM_RD) begin
            latch <= PLANE_RDATA;
        end
    end

    // ===========================================
    // write path through the plane unit
    pwd_alu_if alu_bus();
    assign alu_bus.host_data = HOST_WDATA;
    assign alu_bus.latch = latch;
    assign alu_bus.write_mode = pwd_wmode_t'(wmode);
    assign alu_bus.func = pwd_func_t'(func_sel);
    assign alu_bus.rot_cnt = rot_cnt;
    assign alu_bus.bit_mask = write_bit_mask;
    assign alu_bus.sr_value = SR_VALUE;
    assign alu_bus.sr_enable = SR_ENABLE;

    pwd_plane_alu u_alu (
        .bus(alu_bus.alu)
    );

    // write results are registered at the memory port: data held until the next write, enables for one cycle
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            PLANE_WDATA <= {4{PWD_RST_BYTE}};
            PLANE_WE <= PWD_RST_NIB;
        end else begin
            PLANE_WE <= MEM_WR ? next_plane_we : PWD_RST_NIB;
            if (MEM_WR) begin
                PLANE_WDATA <= alu_bus.plane_data;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            PLANE_A0 <= 1'b0;
        end else if (MEM_WR || MEM_RD) begin
            PLANE_A0 <= next_plane_a0;
        end
    end
endmodule // pwd_datapath

// File: sim/pwd_datapath_checker.sv
// port-level assertions for the planar datapath
`timescale 1ns/1ps
module pwd_datapath_checker (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic MEM_WR,
    input wire logic MEM_RD,
    input wire logic HOST_A0,
    input wire logic HOST_A_HIGH,
    input wire logic [7:0] HOST_RDATA,
    input wire logic HOST_RVALID,
    input wire logic [31:0] PLANE_WDATA,
    input wire logic [3:0] PLANE_WE,
    input wire logic PLANE_A0,
    input wire logic CHAIN_EN,
    input wire logic ATTR_LOAD_256,
    input wire logic ATTR_LOAD_ALT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // ===========================================
    // memory write and read answers
    sequence s_we_all; ##1 (PLANE_WE == 4'hF); endsequence
    sequence s_read; MEM_RD ##1 HOST_RVALID; endsequence
    property p_we_all; MEM_WR && !CHAIN_EN |-> s_we_all; endproperty
    a_we_all: assert property (p_we_all)
        else $error("unchained write missed a plane");
    property p_we_pair;
        MEM_WR && CHAIN_EN |=> PLANE_WE == ($past(HOST_A0) ? 4'hA : 4'h5);
    endproperty
    a_we_pair: assert property (p_we_pair)
        else $error("chained write enabled wrong planes");
    property p_a0_chain; MEM_WR && CHAIN_EN |=> PLANE_A0 == $past(HOST_A_HIGH);
    endproperty
    a_a0_chain: assert property (p_a0_chain)
        else $error("chained address bit 0 not replaced");
    property p_we_idle; !MEM_WR |=> PLANE_WE == 4'h0; endproperty
    a_we_idle: assert property (p_we_idle)
        else $error("plane write without host write");
    property p_wdata_hold; !MEM_WR |=> $stable(PLANE_WDATA); endproperty
    a_wdata_hold: assert property (p_wdata_hold)
        else $error("plane data moved without write");
    property p_rvalid; MEM_RD |-> s_read; endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read not answered next cycle");
    property p_rv_idle; !MEM_RD |=> !HOST_RVALID; endproperty
    a_rv_idle: assert property (p_rv_idle)
        else $error("read answer without read");
    property p_rdata_hold; !MEM_RD |=> $stable(HOST_RDATA); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");
    property p_attr; ATTR_LOAD_256 |-> !ATTR_LOAD_ALT; endproperty
    a_attr: assert property (p_attr)
        else $error("both shift-register loadings selected");
endmodule // pwd_datapath_checker
bind pwd_datapath pwd_datapath_checker pwd_datapath_checker_inst (.MCLK,
    .RST_B, .MEM_WR, .MEM_RD, .HOST_A0, .HOST_A_HIGH, .HOST_RDATA,
    .HOST_RVALID, .PLANE_WDATA, .PLANE_WE, .PLANE_A0, .CHAIN_EN,
    .ATTR_LOAD_256, .ATTR_LOAD_ALT);

// File: sim/pwd_plane_mem.sv
// display-memory planes model, one byte per plane
`timescale 1ns/1ps
module pwd_plane_mem #(
    parameter logic [31:0] INIT = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic rd,
    input wire logic [3:0] we,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    logic [31:0] mem = INIT;
    // bus undriven outside a read: inverse so stale sampling shows up
    assign rdata = rd ? mem : ~mem;
    always @(posedge clk) begin
        for (int p = 0; p < 4; p++) begin
            if (we[p]) begin
                mem[8*p +: 8] <= wdata[8*p +: 8];
            end
        end
    end
endmodule // pwd_plane_mem

// File: sim/pwd_datapath_tb_top.sv
// self-checking bench for the planar datapath
`timescale 1ns/1ps
module pwd_datapath_tb_top;
    import pwd_pkg::*;
    localparam logic [31:0] INIT = 32'hF0CC_AA0F;
    logic MCLK = 1'b0, RST_B = 1'b0, IO_WR = 1'b0, IO_RD = 1'b0;
    logic IO_DATA_SEL = 1'b0, MEM_WR = 1'b0, MEM_RD = 1'b0;
    logic HOST_A0 = 1'b0, HOST_A_HIGH = 1'b0;
    logic [7:0] IO_WDATA = 8'h00, HOST_WDATA = 8'h00;
    logic [3:0] SR_VALUE = 4'h3, SR_ENABLE = 4'h5, CMP_COLOR = 4'h0;
    logic [7:0] IO_RDATA, HOST_RDATA;
    logic HOST_RVALID, PLANE_A0, GRAPHICS_MODE, CHAIN_EN;
    logic ATTR_LOAD_256, ATTR_LOAD_ALT;
    logic [31:0] PLANE_RDATA, PLANE_WDATA, lastw;
    logic [3:0] PLANE_WE;
    logic [1:0] MEMORY_MAP;
    int num_errors = 0, checks = 0;
    pwd_datapath pwd_datapath_inst (.MCLK, .RST_B, .IO_WR, .IO_RD,
        .IO_DATA_SEL, .IO_WDATA, .IO_RDATA, .SR_VALUE, .SR_ENABLE,
        .CMP_COLOR, .MEM_WR, .MEM_RD, .HOST_A0, .HOST_A_HIGH, .HOST_WDATA,
        .HOST_RDATA, .HOST_RVALID, .PLANE_RDATA, .PLANE_WDATA, .PLANE_WE,
        .PLANE_A0, .MEMORY_MAP, .GRAPHICS_MODE, .CHAIN_EN, .ATTR_LOAD_256,
        .ATTR_LOAD_ALT);
    pwd_plane_mem #(.INIT(INIT)) pwd_plane_mem_inst (.clk(MCLK),
        .rd(MEM_RD), .we(PLANE_WE), .wdata(PLANE_WDATA), .rdata(PLANE_RDATA));
    initial begin
        forever #4 MCLK = ~MCLK;
    end
    // ===========================================
    // access tasks
    task step;
        @(posedge MCLK);
        #1;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task hang_if(input logic hang);
        if (hang) begin
            num_errors++;
            $display("wrong value at %0t: no answer", $time);
            give_verdict;
        end
    endtask
    // index port then data port, back to back
    task reg_wr(input logic [3:0] i, input logic [7:0] v);
        IO_WR = 1'b1;
        IO_DATA_SEL = 1'b0;
        IO_WDATA = {4'h0, i};
        step;
        IO_DATA_SEL = 1'b1;
        IO_WDATA = v;
        step;
        IO_WR = 1'b0;
        step;
    endtask
    task reg_rd(input logic [3:0] i, output logic [7:0] q);
        IO_WR = 1'b1;
        IO_DATA_SEL = 1'b0;
        IO_WDATA = {4'h0, i};
        step;
        IO_WR = 1'b0;
        IO_RD = 1'b1;
        IO_DATA_SEL = 1'b1;
        step;
        IO_RD = 1'b0;
        q = IO_RDATA;
        step;
    endtask
    task mem_rd(input logic a0, output logic [7:0] q);
        int n;
        n = 0;
        MEM_RD = 1'b1;
        HOST_A0 = a0;
        step;
        MEM_RD = 1'b0;
        while (HOST_RVALID !== 1'b1 && n < 8) begin
            step;
            n++;
        end
        hang_if(n == 8);
        q = HOST_RDATA;
        step;
    endtask
    task mem_wr(input logic a0, input logic [7:0] d, input logic [31:0] ew,
                input logic [3:0] ewe);
        int n;
        n = 0;
        MEM_WR = 1'b1;
        HOST_A0 = a0;
        HOST_WDATA = d;
        step;
        MEM_WR = 1'b0;
        while (PLANE_WE === 4'h0 && n < 8) begin
            step;
            n++;
        end
        hang_if(n == 8);
        chk(PLANE_WDATA, ew);
        chk({28'h0, PLANE_WE}, {28'h0, ewe});
        step;
    endtask
    // ===========================================
    // expected values, latches holding INIT
    function automatic logic [7:0] rot(input logic [7:0] d,
                                       input logic [2:0] n);
        logic [7:0] r;
        r = d;
        for (int k = 0; k < n; k++) r = {r[0], r[7:1]};
        return r;
    endfunction
    function automatic logic [31:0] exp_wr(input logic [1:0] md,
        input logic [1:0] f, input logic [7:0] m, input logic [7:0] d);
        logic [7:0] s, a, l, mk;
        logic [31:0] w;
        for (int p = 0; p < 4; p++) begin
            l = INIT[8*p +: 8];
            s = (md == 2'd2) ? {8{d[p]}} : rot(d, 3'd3);
            if (md == 2'd3 || SR_ENABLE[p]) s = {8{SR_VALUE[p]}};
            mk = (md == 2'd3) ? (rot(d, 3'd3) & m) : m;
            case (f)
                2'd0: a = s;
                2'd1: a = s & l;
                2'd2: a = s | l;
                default: a = s ^ l;
            endcase
            w[8*p +: 8] = (md == 2'd1) ? l : ((a & mk) | (l & ~mk));
        end
        return w;
    endfunction
    function automatic logic [7:0] exp_cmp(input logic [31:0] pl,
        input logic [3:0] c, input logic [3:0] care);
        logic [7:0] r;
        r = 8'hFF;
        for (int i = 0; i < 8; i++)
            for (int p = 0; p < 4; p++)
                if (care[p] && pl[8*p+i] != c[p]) r[i] = 1'b0;
        return r;
    endfunction
    // ===========================================
    // main sequence
    initial begin
        logic [7:0] q;
        repeat (12) @(posedge MCLK);
        #1 RST_B = 1'b1;
        reg_rd(4'h8, q);
        chk(q, 8'hFF);
        reg_wr(4'h3, 8'hFF);
        reg_rd(4'h3, q);
        chk(q, 8'h1F);
        reg_wr(4'h5, 8'hFF);
        reg_rd(4'h5, q);
        chk(q, 8'h5B);
        chk(ATTR_LOAD_256, 1'b1);
        reg_wr(4'h6, 8'h0D);
        chk({MEMORY_MAP, CHAIN_EN, GRAPHICS_MODE}, 4'hD);
        reg_rd(4'h9, q);
        chk(q, 8'h00);
        reg_wr(4'h5, 8'h00);
        reg_wr(4'h6, 8'h00);
        for (int p = 0; p < 4; p++) begin
            reg_wr(4'h4, 8'(p));
            mem_rd(1'b0, q);
            chk(q, INIT[8*p +: 8]);
        end
        reg_wr(4'h8, 8'h3C);
        for (logic [2:0] md = 0; md < 4; md++) begin
            for (logic [2:0] f = 0; f < 4; f++) begin
                reg_wr(4'h5, {6'h0, md[1:0]});
                reg_wr(4'h3, {3'h0, f[1:0], 3'd3});
                lastw = exp_wr(md[1:0], f[1:0], 8'h3C, 8'hA5);
                mem_wr(1'b0, 8'hA5, lastw, 4'hF);
            end
        end
        reg_wr(4'h5, 8'h08);
        CMP_COLOR = 4'hA;
        reg_wr(4'h7, 8'h0F);
        mem_rd(1'b0, q);
        chk(q, exp_cmp(lastw, 4'hA, 4'hF));
        reg_wr(4'h7, 8'h05);
        mem_rd(1'b0, q);
        chk(q, exp_cmp(lastw, 4'hA, 4'h5));
        reg_wr(4'h5, 8'h10);
        reg_wr(4'h4, 8'h01);
        mem_rd(1'b0, q);
        chk(q, lastw[7:0]);
        mem_rd(1'b1, q);
        chk(q, lastw[15:8]);
        reg_wr(4'h5, 8'h01);
        reg_wr(4'h6, 8'h02);
        HOST_A_HIGH = 1'b1;
        mem_wr(1'b1, 8'h00, lastw, 4'hA);
        give_verdict;
    end
endmodule // pwd_datapath_tb_top
